// ==== cantx_defines.svh ====
// Purpose: Constants for the transmit mailbox controller
// Assumes: 32-bit APB, byte addresses
// Notes:   Included by the package and the design modules
`ifndef CANTX_DEFINES_SVH
`define CANTX_DEFINES_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define CANTX_NMB          16
`define CANTX_IDXW         4
`define CANTX_LAST_IDX     4'hf

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CANTX_A_CONFIG     12'h000
`define CANTX_A_FLAG       12'h004
`define CANTX_A_MASK       12'h008
`define CANTX_A_STATUS     12'h00c
`define CANTX_MB_PAGE      4'h1
`define CANTX_W_CS         2'h0
`define CANTX_W_ID         2'h1
`define CANTX_W_D0         2'h2
`define CANTX_W_D1         2'h3

// ----------------------------------------------------------------
// Fields and codes
// ----------------------------------------------------------------
`define CANTX_CFG_CANCEN   0
`define CANTX_CODE_HI      27
`define CANTX_CODE_LO      24
`define CANTX_DLC_HI       19
`define CANTX_DLC_LO       16
`define CANTX_C_OFF        4'h0
`define CANTX_C_INACT      4'h8
`define CANTX_C_ABORT      4'h9
`define CANTX_C_SEND       4'hc
`define CANTX_RST_WORD     32'h0000_0000
`define CANTX_RST_MASK     16'h0000

`endif

// ==== cantx_pkg.sv ====
// Purpose: Types for the transmit mailbox controller
// Assumes: cantx_defines.svh present
// Notes:   Shared by the scanner and the top
`include "cantx_defines.svh"

package cantx_pkg;

  typedef logic [`CANTX_IDXW-1:0] cantx_idx_t;

  typedef enum logic [1:0] {
    CANTX_S_IDLE = 2'b00,
    CANTX_S_SCAN = 2'b01,
    CANTX_S_DONE = 2'b10
  } cantx_scan_e;

endpackage

// ==== cantx_scan_if.sv ====
// Purpose: Link between the top and the arbitration scanner
// Assumes: One clock domain
// Notes:   Scanner walks one mailbox per cycle
`timescale 1ns/1ps

interface cantx_scan_if;
  import cantx_pkg::*;
  logic        req;
  logic        restart;
  logic        take;
  logic        busy;
  cantx_idx_t  idx;
  logic        pend;
  logic [28:0] id;
  logic        win_valid;
  cantx_idx_t  win_idx;

  modport top  (output req, restart, pend, id,
                input  take, busy, idx, win_valid, win_idx);
  modport scan (input  req, restart, pend, id,
                output take, busy, idx, win_valid, win_idx);
endinterface

// ==== cantx_scan.sv ====
// Purpose: Arbitration scan over the transmit mailboxes
// Assumes: Lower identifier wins, ties go to lower index
// Notes:   One mailbox looked at per clock
`timescale 1ns/1ps
`include "cantx_defines.svh"

module cantx_scan
  import cantx_pkg::*;
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rstn_i,
  // Top side
  cantx_scan_if.scan sif
);

  cantx_scan_e state;
  cantx_scan_e next_state;
  cantx_idx_t  idx;
  cantx_idx_t  next_idx;
  logic        best_valid;
  logic        next_best_valid;
  cantx_idx_t  best_idx;
  cantx_idx_t  next_best_idx;
  logic [28:0] best_id;
  logic [28:0] next_best_id;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state      = state;
    next_idx        = idx;
    next_best_valid = best_valid;
    next_best_idx   = best_idx;
    next_best_id    = best_id;
    case (state)
      CANTX_S_IDLE: begin
        if (sif.req) begin
          next_state      = CANTX_S_SCAN;
          next_idx        = '0;
          next_best_valid = 1'b0;
        end
      end
      CANTX_S_SCAN: begin
        if (sif.restart) begin
          next_idx        = '0; // R12
          next_best_valid = 1'b0;
        end else begin
          if (sif.pend && (!best_valid || sif.id < best_id)) begin
            next_best_valid = 1'b1;
            next_best_idx   = idx;
            next_best_id    = sif.id;
          end
          if (idx == `CANTX_LAST_IDX) begin
            next_state = CANTX_S_DONE;
          end else begin
            next_idx = idx + 1'b1;
          end
        end
      end
      CANTX_S_DONE: next_state = CANTX_S_IDLE;
      default:      next_state = CANTX_S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state      <= CANTX_S_IDLE;
      idx        <= '0;
      best_valid <= 1'b0;
      best_idx   <= '0;
      best_id    <= '0;
    end else begin
      state      <= next_state;
      idx        <= next_idx;
      best_valid <= next_best_valid;
      best_idx   <= next_best_idx;
      best_id    <= next_best_id;
    end
  end

  assign sif.take      = (state == CANTX_S_IDLE) && sif.req;
  assign sif.busy      = (state == CANTX_S_SCAN);
  assign sif.idx       = idx;
  assign sif.win_valid = (state == CANTX_S_DONE) && best_valid;
  assign sif.win_idx   = best_idx;

endmodule // cantx_scan

// ==== cantx_mbox_ctrl.sv ====
// Purpose: Transmit mailbox control with APB registers
// Assumes: APB slave, zero wait states, one clock
// Notes:   Frames go out on a simple request/done port
//
// Notes on behaviour
// R1 - Software cancels a pending send by writing code 1001 to its state code.
// R2 - After a cancel the buffer flag rises; the code shows aborted or sent.
// R3 - Buffer flags are pollable; interrupt only where the buffer mask bit is set.
// R4 - With cancel disabled, code 1000 deactivates silently; frame may still go.
// R5 - Software prepares: clear flag, cancel, write id, data, then control word.
// R6 - Code 1100 activates a buffer; it joins the next arbitration scan.
// R7 - Code 0000 deactivates a buffer so id and data may be changed.
// R8 - Any control word write after intermission triggers a fresh mailbox scan.
// R9 - Software keeps the first mailbox permanently inactive with code 1000.
// R10 - Software writes 1000 twice into that first mailbox to force a rescan.
// R11 - The reserved first mailbox is never used to send or receive.
// R12 - Activation written just before its buffer is scanned is never missed.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "cantx_defines.svh"

module cantx_mbox_ctrl
  import cantx_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Frame port toward the bus engine
  input  wire logic        bus_idle_i,
  input  wire logic        frame_done_i,
  input  wire logic        frame_lost_i,
  output logic             frame_valid_o,
  output logic      [28:0] frame_id_o,
  output logic      [3:0]  frame_dlc_o,
  output logic      [63:0] frame_data_o,
  // Event request
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0]       mb_cs [`CANTX_NMB];
  logic [31:0]       mb_id [`CANTX_NMB];
  logic [31:0]       mb_d0 [`CANTX_NMB];
  logic [31:0]       mb_d1 [`CANTX_NMB];
  logic [31:0]       next_cs [`CANTX_NMB];
  logic [31:0]       next_id [`CANTX_NMB];
  logic [31:0]       next_d0 [`CANTX_NMB];
  logic [31:0]       next_d1 [`CANTX_NMB];
  logic              cancel_enable;
  logic              next_cancel_enable;
  logic [15:0]       buffer_event_flag;
  logic [15:0]       next_buffer_event_flag;
  logic [15:0]       buffer_event_mask;
  logic [15:0]       next_buffer_event_mask;
  logic              rescan;
  logic              next_rescan;
  logic              tx_busy;
  logic              next_tx_busy;
  cantx_idx_t        tx_idx;
  cantx_idx_t        next_tx_idx;
  logic [31:0]       next_prdata;
  logic              next_pready;
  logic              next_pslverr;
  logic [28:0]       next_frame_id;
  logic [3:0]        next_frame_dlc;
  logic [63:0]       next_frame_data;
  logic              next_irq;

  logic              acc;
  logic              wr;
  logic              mb_hit;
  cantx_idx_t        a_idx;
  logic [1:0]        a_word;
  logic              cs_wr;
  logic [3:0]        wcode;

  cantx_scan_if sif ();

  cantx_scan u_scan (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .sif     (sif)
  );

  function automatic logic [3:0] code_of(input logic [31:0] w);
    code_of = w[`CANTX_CODE_HI:`CANTX_CODE_LO];
  endfunction

  function automatic logic [31:0] with_code(input logic [31:0] w, input logic [3:0] c);
    with_code = w;
    with_code[`CANTX_CODE_HI:`CANTX_CODE_LO] = c;
  endfunction

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign acc    = psel_i && penable_i && pready_o;
  assign wr     = acc && pwrite_i;
  assign mb_hit = (paddr_i[11:8] == `CANTX_MB_PAGE);
  assign a_idx  = paddr_i[7:4];
  assign a_word = paddr_i[3:2];
  assign cs_wr  = wr && mb_hit && (a_word == `CANTX_W_CS);
  assign wcode  = code_of(pwdata_i);

  // Scanner view of the mailbox under scan
  assign sif.pend    = (code_of(mb_cs[sif.idx]) == `CANTX_C_SEND)
                       && !(tx_busy && tx_idx == sif.idx); // R6
  assign sif.id      = mb_id[sif.idx][28:0];
  assign sif.req     = rescan;
  assign sif.restart = cs_wr && (wcode == `CANTX_C_SEND); // R12

  // ----------------------------------------------------------------
  // Mailboxes, flags and transmit control
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `CANTX_NMB; i++) begin
      next_cs[i] = mb_cs[i];
      next_id[i] = mb_id[i];
      next_d0[i] = mb_d0[i];
      next_d1[i] = mb_d1[i];
    end
    next_cancel_enable     = cancel_enable;
    next_buffer_event_flag = buffer_event_flag;
    next_buffer_event_mask = buffer_event_mask;
    next_rescan            = rescan && !sif.take;
    next_tx_busy           = tx_busy;
    next_tx_idx            = tx_idx;
    next_frame_id          = frame_id_o;
    next_frame_dlc         = frame_dlc_o;
    next_frame_data        = frame_data_o;

    // Software writes
    if (wr && !mb_hit) begin
      case (paddr_i)
        `CANTX_A_CONFIG: next_cancel_enable = pwdata_i[`CANTX_CFG_CANCEN];
        `CANTX_A_FLAG:   next_buffer_event_flag = buffer_event_flag & ~pwdata_i[15:0];
        `CANTX_A_MASK:   next_buffer_event_mask = pwdata_i[15:0];
        default:         next_cancel_enable = cancel_enable;
      endcase
    end
    if (wr && mb_hit) begin
      case (a_word)
        `CANTX_W_CS: begin
          next_cs[a_idx] = pwdata_i;
          next_rescan    = 1'b1; // R8
          if (wcode == `CANTX_C_ABORT) begin
            if (!cancel_enable) begin
              next_cs[a_idx] = with_code(pwdata_i, `CANTX_C_INACT); // R4
            end else if (code_of(mb_cs[a_idx]) != `CANTX_C_SEND) begin
              next_cs[a_idx] = with_code(pwdata_i, code_of(mb_cs[a_idx]));
            end else if (!(tx_busy && tx_idx == a_idx)) begin
              next_buffer_event_flag[a_idx] = 1'b1; // R2
            end
          end
        end
        `CANTX_W_ID: next_id[a_idx] = pwdata_i;
        `CANTX_W_D0: next_d0[a_idx] = pwdata_i;
        default:     next_d1[a_idx] = pwdata_i;
      endcase
    end

    // Frame finished on the bus
    if (tx_busy && (frame_done_i || frame_lost_i)) begin
      next_tx_busy = 1'b0;
      next_rescan  = 1'b1;
      case (code_of(next_cs[tx_idx]))
        `CANTX_C_SEND: begin
          if (frame_done_i) begin
            next_cs[tx_idx] = with_code(next_cs[tx_idx], `CANTX_C_INACT);
            next_buffer_event_flag[tx_idx] = 1'b1; // R3
          end
        end
        `CANTX_C_ABORT: begin
          if (frame_done_i) begin
            next_cs[tx_idx] = with_code(next_cs[tx_idx], `CANTX_C_INACT);
          end
          next_buffer_event_flag[tx_idx] = 1'b1; // R2
        end
        default: next_tx_busy = 1'b0; // R4
      endcase
    end

    // Launch the scan winner
    if (sif.win_valid && !tx_busy && bus_idle_i
        && code_of(mb_cs[sif.win_idx]) == `CANTX_C_SEND) begin
      next_tx_busy    = 1'b1;
      next_tx_idx     = sif.win_idx;
      next_frame_id   = mb_id[sif.win_idx][28:0];
      next_frame_dlc  = mb_cs[sif.win_idx][`CANTX_DLC_HI:`CANTX_DLC_LO];
      next_frame_data = {mb_d0[sif.win_idx], mb_d1[sif.win_idx]};
    end else if (sif.win_valid && !tx_busy) begin
      next_rescan = 1'b1;
    end

    next_irq = |(next_buffer_event_flag & next_buffer_event_mask); // R3
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_comb begin
    next_pready  = psel_i && !penable_i;
    next_pslverr = 1'b0;
    next_prdata  = '0;
    if (psel_i && !penable_i) begin
      if (mb_hit) begin
        case (a_word)
          `CANTX_W_CS: next_prdata = mb_cs[a_idx]; // R2
          `CANTX_W_ID: next_prdata = mb_id[a_idx];
          `CANTX_W_D0: next_prdata = mb_d0[a_idx];
          default:     next_prdata = mb_d1[a_idx];
        endcase
      end else begin
        case (paddr_i)
          `CANTX_A_CONFIG: next_prdata = {31'h0, cancel_enable};
          `CANTX_A_FLAG:   next_prdata = {16'h0, buffer_event_flag};
          `CANTX_A_MASK:   next_prdata = {16'h0, buffer_event_mask};
          `CANTX_A_STATUS: next_prdata = {24'h0, sif.busy, rescan, 1'b0,
                                          tx_busy, tx_idx};
          default:         next_pslverr = 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < `CANTX_NMB; i++) begin
        mb_cs[i] <= `CANTX_RST_WORD;
        mb_id[i] <= `CANTX_RST_WORD;
        mb_d0[i] <= `CANTX_RST_WORD;
        mb_d1[i] <= `CANTX_RST_WORD;
      end
      cancel_enable     <= 1'b0;
      buffer_event_flag <= `CANTX_RST_MASK;
      buffer_event_mask <= `CANTX_RST_MASK;
      rescan            <= 1'b0;
      tx_busy           <= 1'b0;
      tx_idx            <= '0;
      prdata_o          <= '0;
      pready_o          <= 1'b0;
      pslverr_o         <= 1'b0;
      frame_valid_o     <= 1'b0;
      frame_id_o        <= '0;
      frame_dlc_o       <= '0;
      frame_data_o      <= '0;
      irq_o             <= 1'b0;
    end else begin
      for (int i = 0; i < `CANTX_NMB; i++) begin
        mb_cs[i] <= next_cs[i];
        mb_id[i] <= next_id[i];
        mb_d0[i] <= next_d0[i];
        mb_d1[i] <= next_d1[i];
      end
      cancel_enable     <= next_cancel_enable;
      buffer_event_flag <= next_buffer_event_flag;
      buffer_event_mask <= next_buffer_event_mask;
      rescan            <= next_rescan;
      tx_busy           <= next_tx_busy;
      tx_idx            <= next_tx_idx;
      prdata_o          <= next_prdata;
      pready_o          <= next_pready;
      pslverr_o         <= next_pslverr;
      frame_valid_o     <= next_tx_busy;
      frame_id_o        <= next_frame_id;
      frame_dlc_o       <= next_frame_dlc;
      frame_data_o      <= next_frame_data;
      irq_o             <= next_irq;
    end
  end

endmodule // cantx_mbox_ctrl

// ==== cantx_mbox_ctrl_monitor.sv ====
// Purpose: Port checker for the mailbox controller
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to the top module
`timescale 1ns/1ps
`include "cantx_defines.svh"

module cantx_mbox_ctrl_monitor (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rstn_i,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Frame port
  input wire logic        bus_idle_i,
  input wire logic        frame_done_i,
  input wire logic        frame_lost_i,
  input wire logic        frame_valid_o,
  input wire logic [28:0] frame_id_o,
  input wire logic [3:0]  frame_dlc_o,
  input wire logic [63:0] frame_data_o,
  // Event request
  input wire logic        irq_o
);
  // ----
  // Helpers
  // ----
  logic        acc;
  logic        cs_wr;
  logic [3:0]  code;
  logic [15:0] mask_q;
  assign acc   = psel_i && penable_i && pready_o && pwrite_i;
  assign cs_wr = acc && paddr_i[11:8] == `CANTX_MB_PAGE && paddr_i[3:2] == `CANTX_W_CS;
  assign code  = pwdata_i[`CANTX_CODE_HI:`CANTX_CODE_LO];
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      mask_q <= `CANTX_RST_MASK;
    end else if (acc && paddr_i == `CANTX_A_MASK) begin
      mask_q <= pwdata_i[15:0];
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  property p_rdy;   psel_i && !penable_i |=> pready_o; endproperty
  property p_rdy1;  pready_o |=> !pready_o; endproperty
  property p_err;   pslverr_o |-> pready_o; endproperty
  property p_errd;  pslverr_o && !pwrite_i |-> prdata_o == 32'h0; endproperty
  property p_irq;   irq_o |-> mask_q != 16'h0; endproperty
  property p_launch;
    cs_wr && code == `CANTX_C_SEND |->
      ##[1:200] (frame_valid_o || (cs_wr && code == `CANTX_C_ABORT));
  endproperty
  property p_hold;
    frame_valid_o && !frame_done_i && !frame_lost_i |=> frame_valid_o &&
      $stable(frame_id_o) && $stable(frame_dlc_o) && $stable(frame_data_o);
  endproperty
  property p_gap;   frame_valid_o && (frame_done_i || frame_lost_i) |=> !frame_valid_o [*8];
  endproperty

  a_rdy:    assert property (p_rdy)    else $error("no ready after setup");
  a_rdy1:   assert property (p_rdy1)   else $error("ready longer than one cycle");
  a_err:    assert property (p_err)    else $error("error without ready");
  a_errd:   assert property (p_errd)   else $error("error read data not zero");
  a_irq:    assert property (p_irq)    else $error("request with all masked");
  a_launch: assert property (p_launch) else $error("activated buffer not sent");
  a_hold:   assert property (p_hold)   else $error("frame changed in flight");
  a_gap:    assert property (p_gap)    else $error("relaunch before rescan");

  cover property (frame_valid_o && frame_done_i);
  cover property (frame_valid_o && frame_lost_i);
  cover property (irq_o);
  cover property (pslverr_o);
endmodule // cantx_mbox_ctrl_monitor

bind cantx_mbox_ctrl cantx_mbox_ctrl_monitor mon_u (
  .clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .bus_idle_i, .frame_done_i, .frame_lost_i, .frame_valid_o,
  .frame_id_o, .frame_dlc_o, .frame_data_o, .irq_o);

// ==== cantx_node_model.sv ====
// Purpose: Far-side bus engine and other nodes
// Assumes: One frame at a time
// Notes:   Latency and loss set by the bench
`timescale 1ns/1ps

module cantx_node_model (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rstn_i,
  // Bench control
  input  wire logic       lose_i,
  input  wire logic [3:0] lat_i,
  // Frame port
  input  wire logic       frame_valid_i,
  output logic            bus_idle_o,
  output logic            frame_done_o,
  output logic            frame_lost_o
);
  logic       busy;
  logic [3:0] cnt;
  assign bus_idle_o = !busy;
  always_ff @(posedge clock_i) begin
    frame_done_o <= 1'b0;
    frame_lost_o <= 1'b0;
    if (!rstn_i) begin
      busy <= 1'b0;
      cnt  <= 4'h0;
    end else if (frame_valid_i && !busy && !frame_done_o && !frame_lost_o) begin
      busy <= 1'b1;
      cnt  <= lat_i;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      busy         <= 1'b0;
      frame_done_o <= !lose_i;
      frame_lost_o <= lose_i;
    end
  end
endmodule // cantx_node_model

// ==== tb_cantx_mbox_ctrl.sv ====
// Purpose: Self-checking bench for the mailbox controller
// Assumes: APB master, node model on the frame port
// Notes:   Random sends from a fixed seed, then cancel cases
`timescale 1ns/1ps
`include "cantx_defines.svh"
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp); \
    end \
  end

module tb_cantx_mbox_ctrl import cantx_pkg::*;;
  logic        clock_i, rstn_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        pready_o, pslverr_o, bus_idle_i, frame_done_i, frame_lost_i;
  logic        frame_valid_o, irq_o, er, lose;
  logic [28:0] frame_id_o, id;
  logic [3:0]  frame_dlc_o, lat, l;
  logic [63:0] frame_data_o, d;
  logic [15:0] seed, mk;
  cantx_idx_t  m;
  int          fail_count, tests_run;

  cantx_mbox_ctrl dut_u (.clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .bus_idle_i, .frame_done_i,
    .frame_lost_i, .frame_valid_o, .frame_id_o, .frame_dlc_o, .frame_data_o, .irq_o);
  cantx_node_model node_u (.clock_i, .rstn_i, .lose_i(lose), .lat_i(lat),
    .frame_valid_i(frame_valid_o), .bus_idle_o(bus_idle_i), .frame_done_o(frame_done_i),
    .frame_lost_o(frame_lost_i));

  // ----
  // Helpers
  // ----
  function automatic logic [15:0] nxt();
    seed = {seed[14:0], ^(seed & 16'hb400)};
    return seed;
  endfunction
  function automatic logic [11:0] mba(input logic [3:0] n, input logic [1:0] w);
    return {`CANTX_MB_PAGE, n, w, 2'b00};
  endfunction
  function automatic logic [31:0] csw(input logic [3:0] c, input logic [3:0] n);
    return {4'h0, c, 4'h0, n, 16'h0};
  endfunction
  task automatic results();
    $display("counts: %0d compares, %0d mismatches", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tmo();
    `CHK(1'b0, 1'b1)
    results();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge clock_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= v;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) tmo();
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic pollf(input logic [3:0] n);
    int k;
    k = 0;
    do begin
      apb(1'b0, `CANTX_A_FLAG, 32'h0);
      k++;
    end while (rd[n] !== 1'b1 && k < 100);
    if (k >= 100) tmo();
  endtask
  task automatic wfv();
    int k;
    k = 0;
    while (frame_valid_o !== 1'b1 && k < 300) begin
      @(posedge clock_i);
      k++;
    end
    if (k >= 300) tmo();
  endtask
  task automatic prep(input logic [3:0] n);
    apb(1'b1, `CANTX_A_FLAG, 32'hffff);
    apb(1'b1, mba(n, `CANTX_W_CS), csw(`CANTX_C_OFF, 4'h0));
    apb(1'b1, mba(n, `CANTX_W_ID), {3'h0, id});
    apb(1'b1, mba(n, `CANTX_W_D0), d[63:32]);
    apb(1'b1, mba(n, `CANTX_W_D1), d[31:0]);
    apb(1'b1, mba(n, `CANTX_W_CS), csw(`CANTX_C_SEND, l));
    apb(1'b1, mba(4'h0, `CANTX_W_CS), csw(`CANTX_C_INACT, 4'h0));
    apb(1'b1, mba(4'h0, `CANTX_W_CS), csw(`CANTX_C_INACT, 4'h0));
  endtask

  // ----
  // Stimulus
  // ----
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    {rstn_i, psel_i, penable_i, pwrite_i, lose} = '0;
    {paddr_i, pwdata_i, lat} = '0;
    {fail_count, tests_run} = '0;
    seed = 16'hfb4c;
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    apb(1'b0, `CANTX_A_CONFIG, 32'h0);
    `CHK(rd, `CANTX_RST_WORD)
    apb(1'b0, `CANTX_A_MASK, 32'h0);
    `CHK(rd[15:0], `CANTX_RST_MASK)
    apb(1'b0, 12'h020, 32'h0);
    `CHK({er, rd}, 33'h1_0000_0000)
    apb(1'b0, `CANTX_A_STATUS, 32'h0);
    `CHK(rd, `CANTX_RST_WORD)
    $display("test reset done");
    apb(1'b1, mba(4'h0, `CANTX_W_CS), csw(`CANTX_C_INACT, 4'h0));
    for (int k = 0; k < 8; k++) begin
      m   = (k == 0) ? 4'hf : 4'(nxt() % 16'h000f) + 4'h1;
      id  = (k == 1) ? '1 : 29'({nxt(), nxt()});
      d   = {nxt(), nxt(), nxt(), nxt()};
      l   = 4'(nxt());
      mk  = nxt();
      lat <= (k == 2) ? 4'h0 : 4'(nxt());
      apb(1'b1, `CANTX_A_MASK, {16'h0, mk});
      prep(m);
      wfv();
      `CHK({frame_id_o, frame_dlc_o, frame_data_o}, {id, l, d})
      apb(1'b0, `CANTX_A_STATUS, 32'h0);
      `CHK(rd[4:0], {1'b1, m})
      pollf(m);
      apb(1'b0, mba(m, `CANTX_W_CS), 32'h0);
      `CHK(rd[27:24], `CANTX_C_INACT)
      `CHK(irq_o, mk[m])
      apb(1'b1, `CANTX_A_FLAG, 32'hffff);
      repeat (2) @(posedge clock_i);
      `CHK(irq_o, 1'b0)
    end
    $display("test sends done");
    apb(1'b1, `CANTX_A_CONFIG, 32'h1);
    prep(4'h3);
    apb(1'b1, mba(4'h3, `CANTX_W_CS), csw(`CANTX_C_ABORT, l));
    apb(1'b0, `CANTX_A_FLAG, 32'h0);
    `CHK(rd[3], 1'b1)
    apb(1'b0, mba(4'h3, `CANTX_W_CS), 32'h0);
    `CHK(rd[27:24], `CANTX_C_ABORT)
    lose <= 1'b1;
    lat  <= 4'hf;
    prep(4'h5);
    wfv();
    apb(1'b1, mba(4'h5, `CANTX_W_CS), csw(`CANTX_C_ABORT, l));
    pollf(4'h5);
    apb(1'b0, mba(4'h5, `CANTX_W_CS), 32'h0);
    `CHK(rd[27:24], `CANTX_C_ABORT)
    lose <= 1'b0;
    apb(1'b1, `CANTX_A_CONFIG, 32'h0);
    prep(4'h6);
    apb(1'b1, mba(4'h6, `CANTX_W_CS), csw(`CANTX_C_ABORT, l));
    apb(1'b0, mba(4'h6, `CANTX_W_CS), 32'h0);
    `CHK(rd[27:24], `CANTX_C_INACT)
    apb(1'b0, `CANTX_A_FLAG, 32'h0);
    `CHK(rd[6], 1'b0)
    $display("test cancel done");
    results();
  end
endmodule // tb_cantx_mbox_ctrl
